/* File: bench/nna_axi_mem.sv */
// write-only dram model on the bus clock
`timescale 1ns/1ps
module nna_axi_mem (
  input wire logic aclk,
  input wire logic stall,
  input wire logic [7:0] awlen,
  input wire logic awvalid,
  output logic awready,
  input wire logic [63:0] wdata,
  input wire logic wlast,
  input wire logic wvalid,
  output logic wready,
  output logic [8:0] w_cnt,
  output logic [7:0] len_seen,
  output logic [7:0] last_err
);
  logic [63:0] beats [0:255];
  initial begin
    awready = 1'b0;
    wready = 1'b0;
    w_cnt = 9'h000;
    len_seen = 8'h00;
    last_err = 8'h00;
  end
  // ready toggles so prompt and slow answers mix; stall holds the data side off
  always @(posedge aclk) begin
    if (awvalid && awready) begin
      len_seen <= awlen;
      w_cnt <= 9'h000;
    end
    if (wvalid && wready) begin
      beats[w_cnt[7:0]] <= wdata;
      w_cnt <= w_cnt + 9'h001;
      if (wlast !== (w_cnt[7:0] == len_seen)) last_err <= last_err + 8'h01;
    end
    awready <= !awready;
    wready <= !stall && !wready;
  end
endmodule

/* File: bench/nna_top_tb.sv */
// self-checking bench for the host interface shell
`timescale 1ns/1ps
`include "nna_params.svh"
module nna_top_tb;
  logic ref_clk = 1'b0, aclk = 1'b0, rst, start, port_req, port_wr, eng_finish, stall;
  logic eng_gpo_we, eng_res_valid, wr_req_valid, wr_data_valid, axi_awready, axi_wready;
  logic [31:0] code_base, eng_gpo_data, wr_req_addr, gpo, eng_code_base, axi_awaddr;
  logic [16:0] port_ofs;
  logic [15:0] port_wdata, eng_res_data, mem_rdata, port_rdata, result_data, mem_wdata;
  logic [8:0] wr_req_len, w_cnt;
  logic [63:0] wr_data, axi_wdata;
  logic [7:0] act, status, axi_awid, axi_awlen, axi_wid, axi_wstrb, len_seen, last_err;
  logic rd_rdy, port_ready, port_rdata_valid, result_we, eng_start, mem_we, mem_re;
  logic wr_req_ready, wr_data_ready, axi_awlock, axi_awvalid, axi_wlast, axi_wvalid;
  logic axi_bready;
  logic [3:0] mem_bank, axi_awregion, axi_awcache, axi_awqos;
  logic [12:0] mem_addr;
  logic [2:0] axi_awsize, axi_awprot;
  logic [1:0] axi_awburst;
  logic eng_conv_busy, eng_fc_busy, eng_cmd_fifo_rd, eng_dram_access, eng_dram_cmd;
  logic eng_fifo_wait;
  int error_cnt = 0, total_checks = 0, i, n, blk;
  // activity inputs packed at their status positions
  assign {eng_fifo_wait, eng_dram_cmd, eng_dram_access, eng_cmd_fifo_rd} = act[7:4];
  assign {eng_fc_busy, eng_conv_busy} = act[1:0];
  always #2.5 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #62.5 aclk = ~aclk;
  end
  nna_top #(.MAX_BURST(`NNA_BURST_32)) i_dut (.ref_clk, .rst, .start, .code_base, .rd_rdy,
    .status, .gpo, .port_req, .port_wr, .port_ofs, .port_wdata, .port_ready,
    .port_rdata_valid, .port_rdata, .result_we, .result_data, .eng_start, .eng_code_base,
    .eng_finish, .eng_conv_busy, .eng_fc_busy, .eng_cmd_fifo_rd, .eng_dram_access,
    .eng_dram_cmd, .eng_fifo_wait, .eng_gpo_we, .eng_gpo_data, .eng_res_valid,
    .eng_res_data, .mem_we, .mem_re, .mem_bank, .mem_addr, .mem_wdata, .mem_rdata,
    .wr_req_valid, .wr_req_addr, .wr_req_len, .wr_req_ready, .wr_data_valid, .wr_data,
    .wr_data_ready, .aclk, .axi_awid, .axi_awaddr, .axi_awregion, .axi_awlen, .axi_awsize,
    .axi_awburst, .axi_awlock, .axi_awcache, .axi_awprot, .axi_awqos, .axi_awvalid,
    .axi_awready, .axi_wid, .axi_wdata, .axi_wstrb, .axi_wlast, .axi_wvalid, .axi_wready,
    .axi_bready);
  nna_axi_mem i_axi (.aclk, .stall, .awlen(axi_awlen), .awvalid(axi_awvalid),
    .awready(axi_awready), .wdata(axi_wdata), .wlast(axi_wlast), .wvalid(axi_wvalid),
    .wready(axi_wready), .w_cnt, .len_seen, .last_err);
  // compare and count
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // bounded wait for a level on a design output
  task automatic wt(ref logic s, input logic v, input string nm);
    for (int k = 0; k < 100 && s !== v; k++) tick(1);
    chk(nm, v, s);
    if (s !== v) finish_test;
  endtask
  // one input port request held for one take edge
  task automatic port_op(input logic w, input logic [16:0] o, input logic [15:0] d);
    @(posedge ref_clk);
    port_req <= 1'b1;
    port_wr <= w;
    port_ofs <= o;
    port_wdata <= d;
    @(posedge ref_clk);
    port_req <= 1'b0;
    #1;
  endtask
  initial begin
    {rst, start, port_req, port_wr, eng_finish, eng_gpo_we, eng_res_valid} = 7'h7f & 7'h40;
    {wr_req_valid, wr_data_valid, stall, act, code_base, eng_gpo_data} = '0;
    {port_ofs, port_wdata, eng_res_data, wr_req_addr, wr_req_len, wr_data} = '0;
    rst = 1'b1;
    mem_rdata = 16'h3c5a;
    tick(7);
    chk("idle", 6'h3c, {rd_rdy, port_ready, status == 8'h00, gpo == 32'h0, result_we,
      axi_awvalid | axi_wvalid});
    chk("ids", 32'h1010_ff01, {axi_awid, axi_wid, axi_wstrb, 7'h0, axi_bready});
    chk("attr", {3'b011, 2'b01, 1'b0, 4'h0, 3'b000, 4'h0, 4'h0}, {axi_awsize, axi_awburst,
      axi_awlock, axi_awcache, axi_awprot, axi_awregion, axi_awqos});
    @(posedge ref_clk);
    rst <= 1'b0;
    tick(2);
    port_op(1'b1, {4'hf, 13'h1fff}, 16'ha5c3);
    chk("write", {1'b1, 1'b0, 4'hf, 13'h1fff, 16'ha5c3}, {mem_we, mem_re, mem_bank,
      mem_addr, mem_wdata});
    port_op(1'b0, {4'h2, 13'h0001}, 16'h0000);
    chk("read", {1'b1, 1'b0, 4'h2, 13'h0001}, {mem_re, mem_we, mem_bank, mem_addr});
    tick(5);
    chk("read wait", 2'b00, {port_ready, port_rdata_valid});
    tick(1);
    chk("read done", {2'b11, 16'h3c5a}, {port_ready, port_rdata_valid, port_rdata});
    $display("test port done");
    @(posedge ref_clk);
    code_base <= 32'h1234_5670;
    start <= 1'b1;
    wt(rd_rdy, 1'b0, "busy");
    chk("launch", {1'b1, 32'h1234_5670}, {eng_start, eng_code_base});
    @(posedge ref_clk);
    start <= 1'b0;
    #1;
    chk("run status", 9'h008, {eng_start, status});
    for (i = 0; i < 8; i++) begin
      if (i != 2 && i != 3) begin
        @(posedge ref_clk);
        act <= 8'h01 << i;
        tick(2);
        chk("status", 8'h08 | (8'h01 << i), status);
      end
    end
    act <= 8'h00;
    port_op(1'b1, 17'h0_0005, 16'h1111);
    chk("refused", 2'b00, {port_ready, mem_we});
    @(posedge ref_clk);
    eng_gpo_we <= 1'b1;
    eng_gpo_data <= 32'hdead_beef;
    @(posedge ref_clk);
    eng_gpo_we <= 1'b0;
    eng_res_valid <= 1'b1;
    eng_res_data <= 16'h0a0b;
    #1;
    chk("gpo", 32'hdead_beef, gpo);
    @(posedge ref_clk);
    eng_res_data <= 16'h0c0d;
    #1;
    chk("result a", 17'h1_0a0b, {result_we, result_data});
    @(posedge ref_clk);
    eng_res_valid <= 1'b0;
    #1;
    chk("result b", 17'h1_0c0d, {result_we, result_data});
    @(posedge ref_clk);
    eng_finish <= 1'b1;
    #1;
    chk("result end", 1'b0, result_we);
    @(posedge ref_clk);
    eng_finish <= 1'b0;
    #1;
    chk("finish", 2'b11, {rd_rdy, port_ready});
    $display("test run done");
    stall <= 1'b1;
    chk("req ready", 1'b1, wr_req_ready);
    @(posedge ref_clk);
    wr_req_valid <= 1'b1;
    wr_req_addr <= 32'h0f00_0000;
    wr_req_len <= 9'h028;
    @(posedge ref_clk);
    wr_req_valid <= 1'b0;
    wr_data_valid <= 1'b1;
    n = 0;
    blk = 0;
    wr_data <= 64'hcafe_0000_0000_0000;
    // fill the buffer against a stalled bus, then drain
    for (i = 0; i < 3000 && n < 32; i++) begin
      @(posedge ref_clk);
      if (wr_data_ready === 1'b1) n++;
      else blk++;
      if (blk == 50) begin
        chk("fifo full", 2'b11, {n >= 16, status[2]});
        stall <= 1'b0;
      end
      wr_data <= {32'hcafe_0000, n[31:0]};
      wr_data_valid <= (n < 32);
    end
    chk("pushes", 32, n);
    for (i = 0; i < 3000 && w_cnt !== 9'h020; i++) tick(1);
    chk("beats", 9'h020, w_cnt);
    if (i == 3000) finish_test;
    chk("burst", {32'h0f00_0000, 16'h1f00}, {axi_awaddr, len_seen, last_err});
    for (i = 0; i < 32; i++) chk("beat", {32'hcafe_0000, i}, i_axi.beats[i]);
    tick(8);
    chk("burst idle", 1'b1, wr_req_ready);
    $display("test dram done");
    // reset while the engine runs clears everything again
    @(posedge ref_clk);
    start <= 1'b1;
    wt(rd_rdy, 1'b0, "busy again");
    @(posedge ref_clk);
    start <= 1'b0;
    rst <= 1'b1;
    tick(2);
    chk("mid reset", 5'h1f, {rd_rdy, port_ready, status == 8'h00, gpo == 32'h0,
      !axi_awvalid});
    @(posedge ref_clk);
    rst <= 1'b0;
    tick(2);
    chk("after reset", 3'h7, {rd_rdy, port_ready, wr_req_ready});
    $display("test reset done");
    finish_test;
  end
endmodule

/* File: src/nna_fifo.sv */
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module nna_fifo #(
  parameter int W = 64,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // occupancy after this cycle's push and pop
  assign next_count = (push && !pop) ? count + 1'b1 :
                      ((!push && pop) ? count - 1'b1 : count);
  assign out_data = mem[rd_ptr];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and registered full/empty flags
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= next_count != (AW+1)'(D);
      out_valid <= next_count != '0;
    end
  end
endmodule

/* File: src/nna_params.svh */
// constants for the accelerator host interface shell
`ifndef NNA_PARAMS_SVH
`define NNA_PARAMS_SVH

// fixed write-address, write-data and write-response channel values
`define NNA_AWID 8'h10
`define NNA_WSTRB 8'hFF
`define NNA_AWSIZE 3'b011
`define NNA_AWBURST 2'b01
`define NNA_AWLOCK 1'b0
`define NNA_AWCACHE 4'h0
`define NNA_AWPROT 3'b000
`define NNA_AWREGION 4'h0
`define NNA_AWQOS 4'h0
`define NNA_BREADY 1'b1

// burst length limits, in beats
`define NNA_BURST_32 9'h020
`define NNA_BURST_256 9'h100
`define NNA_LEN_ONE 9'h001
`define NNA_LEN_ZERO 9'h000

// input port read latency, in system clock cycles
`define NNA_RD_LAT 4'h7
`define NNA_CNT_ONE 4'h1
`define NNA_CNT_ZERO 4'h0

// input port offset fields
`define NNA_OFS_W 17
`define NNA_WADDR_MSB 12
`define NNA_WADDR_LSB 0
`define NNA_BANK_MSB 16
`define NNA_BANK_LSB 13
`define NNA_PORT_DW 16

// data path widths and buffer depth
`define NNA_AXI_DW 64
`define NNA_AXI_AW 32
`define NNA_FIFO_DEPTH 16

// status bit positions
`define NNA_ST_CONV 0
`define NNA_ST_FC 1
`define NNA_ST_AXI 2
`define NNA_ST_RUN 3
`define NNA_ST_CMDRD 4
`define NNA_ST_DRAM 5
`define NNA_ST_DCMD 6
`define NNA_ST_FWAIT 7

// reset values
`define NNA_ZERO32 32'h0000_0000
`define NNA_ZERO64 64'h0000_0000_0000_0000
`define NNA_ZERO16 16'h0000
`define NNA_ZERO8 8'h00

`endif

/* File: src/nna_pkg.sv */
// types shared by the host interface shell
package nna_pkg;
  typedef enum logic [0:0] {CT_IDLE, CT_RUN} nna_ctl_t;
  typedef enum logic [1:0] {AW_IDLE, AW_ADDR, AW_DATA} nna_aw_t;
endpackage

/* File: src/nna_top.sv */
// host interface shell of the inference engine: control, input port, result, dram write
`timescale 1ns/1ps
`include "nna_params.svh"
module nna_top #(
  parameter logic [8:0] MAX_BURST = `NNA_BURST_256
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [`NNA_AXI_AW-1:0] code_base,
  output logic rd_rdy,
  output logic [7:0] status,
  output logic [31:0] gpo,
  input wire logic port_req,
  input wire logic port_wr,
  input wire logic [`NNA_OFS_W-1:0] port_ofs,
  input wire logic [`NNA_PORT_DW-1:0] port_wdata,
  output logic port_ready,
  output logic port_rdata_valid,
  output logic [`NNA_PORT_DW-1:0] port_rdata,
  output logic result_we,
  output logic [15:0] result_data,
  output logic eng_start,
  output logic [`NNA_AXI_AW-1:0] eng_code_base,
  input wire logic eng_finish,
  input wire logic eng_conv_busy,
  input wire logic eng_fc_busy,
  input wire logic eng_cmd_fifo_rd,
  input wire logic eng_dram_access,
  input wire logic eng_dram_cmd,
  input wire logic eng_fifo_wait,
  input wire logic eng_gpo_we,
  input wire logic [31:0] eng_gpo_data,
  input wire logic eng_res_valid,
  input wire logic [15:0] eng_res_data,
  output logic mem_we,
  output logic mem_re,
  output logic [3:0] mem_bank,
  output logic [12:0] mem_addr,
  output logic [`NNA_PORT_DW-1:0] mem_wdata,
  input wire logic [`NNA_PORT_DW-1:0] mem_rdata,
  input wire logic wr_req_valid,
  input wire logic [`NNA_AXI_AW-1:0] wr_req_addr,
  input wire logic [8:0] wr_req_len,
  output logic wr_req_ready,
  input wire logic wr_data_valid,
  input wire logic [`NNA_AXI_DW-1:0] wr_data,
  output logic wr_data_ready,
  input wire logic aclk,
  output logic [7:0] axi_awid,
  output logic [`NNA_AXI_AW-1:0] axi_awaddr,
  output logic [3:0] axi_awregion,
  output logic [7:0] axi_awlen,
  output logic [2:0] axi_awsize,
  output logic [1:0] axi_awburst,
  output logic axi_awlock,
  output logic [3:0] axi_awcache,
  output logic [2:0] axi_awprot,
  output logic [3:0] axi_awqos,
  output logic axi_awvalid,
  input wire logic axi_awready,
  output logic [7:0] axi_wid,
  output logic [`NNA_AXI_DW-1:0] axi_wdata,
  output logic [7:0] axi_wstrb,
  output logic axi_wlast,
  output logic axi_wvalid,
  input wire logic axi_wready,
  output logic axi_bready
);
  import nna_pkg::*;

  nna_ctl_t ctl;
  nna_aw_t aw_st;
  logic rd_busy;
  logic [3:0] rd_cnt;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] lvl;
  logic [8:0] beats_left;
  logic fifo_valid;
  logic [`NNA_AXI_DW-1:0] fifo_data;
  logic [7:0] next_status;

  // control handshake decode
  wire go_run = (ctl == CT_IDLE) && start && !rd_busy && !(port_req && port_ready && !port_wr);
  wire go_idle = (ctl == CT_RUN) && eng_finish;
  wire next_idle = ((ctl == CT_IDLE) && !go_run) || go_idle;

  // input port decode
  wire port_take = port_req && port_ready;
  wire wr_take = port_take && port_wr;
  wire rd_take = port_take && !port_wr;
  wire rd_done = rd_busy && (rd_cnt == `NNA_RD_LAT - `NNA_CNT_ONE);
  wire next_busy = rd_take || (rd_busy && !rd_done);

  // control state and start pulse toward the engine
  always_ff @(posedge ref_clk) begin
    eng_start <= 1'b0;
    if (rst) begin
      ctl <= CT_IDLE;
      rd_rdy <= 1'b1;
      eng_code_base <= `NNA_ZERO32;
    end else if (go_run) begin
      ctl <= CT_RUN;
      rd_rdy <= 1'b0;
      eng_start <= 1'b1;
      eng_code_base <= code_base;
    end else if (go_idle) begin
      ctl <= CT_IDLE;
      rd_rdy <= 1'b1;
    end
  end

  // input port: writes forward at once, reads wait out the latency
  always_ff @(posedge ref_clk) begin
    mem_we <= wr_take;
    mem_re <= rd_take;
    port_rdata_valid <= 1'b0;
    if (port_take) begin
      mem_bank <= port_ofs[`NNA_BANK_MSB:`NNA_BANK_LSB];
      mem_addr <= port_ofs[`NNA_WADDR_MSB:`NNA_WADDR_LSB];
      mem_wdata <= port_wdata;
    end
    if (rst) begin
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      rd_busy <= 1'b0;
      rd_cnt <= `NNA_CNT_ZERO;
      port_ready <= 1'b1;
      port_rdata <= `NNA_ZERO16;
      mem_bank <= 4'h0;
      mem_addr <= 13'h0000;
      mem_wdata <= `NNA_ZERO16;
    end else begin
      rd_busy <= next_busy;
      rd_cnt <= rd_take ? `NNA_CNT_ONE : (rd_busy ? rd_cnt + `NNA_CNT_ONE : `NNA_CNT_ZERO);
      port_ready <= next_idle && !next_busy;
      if (rd_done) begin
        port_rdata_valid <= 1'b1;
        port_rdata <= mem_rdata;
      end
    end
  end

  // status vector and general purpose output
  assign next_status[`NNA_ST_CONV] = eng_conv_busy;
  assign next_status[`NNA_ST_FC] = eng_fc_busy;
  assign next_status[`NNA_ST_AXI] = aw_st != AW_IDLE;
  assign next_status[`NNA_ST_RUN] = ctl == CT_RUN;
  assign next_status[`NNA_ST_CMDRD] = eng_cmd_fifo_rd;
  assign next_status[`NNA_ST_DRAM] = eng_dram_access || (aw_st != AW_IDLE);
  assign next_status[`NNA_ST_DCMD] = eng_dram_cmd || axi_awvalid;
  assign next_status[`NNA_ST_FWAIT] = eng_fifo_wait;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status <= `NNA_ZERO8;
      gpo <= `NNA_ZERO32;
    end else begin
      status <= next_status;
      if (eng_gpo_we) begin
        gpo <= eng_gpo_data;
      end
    end
  end

  // result strobe and word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_we <= 1'b0;
      result_data <= `NNA_ZERO16;
    end else begin
      result_we <= eng_res_valid;
      if (eng_res_valid) begin
        result_data <= eng_res_data;
      end
    end
  end

  // three-stage sampling of the bus clock and ready pins
  wire [2:0] agree = ~(sync2 ^ sync3);
  wire [2:0] next_lvl = (agree & sync3) | (~agree & lvl);
  wire aclk_rise = next_lvl[0] && !lvl[0];
  wire aw_rdy = lvl[1];
  wire w_rdy = lvl[2];

  always_ff @(posedge ref_clk) begin
    sync1 <= {axi_wready, axi_awready, aclk};
    sync2 <= sync1;
    sync3 <= sync2;
    if (rst) begin
      lvl <= 3'h0;
    end else begin
      lvl <= next_lvl;
    end
  end

  // write burst sequencing, stepped on bus clock edges
  wire [8:0] eff_len = (wr_req_len > MAX_BURST) ? MAX_BURST : wr_req_len;
  wire req_take = wr_req_valid && wr_req_ready;
  wire aw_done = aclk_rise && axi_awvalid && aw_rdy;
  wire w_done = aclk_rise && axi_wvalid && w_rdy;
  wire w_can_load = aclk_rise && (aw_st == AW_DATA) && (beats_left != `NNA_LEN_ZERO)
                    && (!axi_wvalid || (w_rdy && !axi_wlast));
  wire fifo_pop = w_can_load && fifo_valid;
  wire next_aw_idle = ((aw_st == AW_IDLE) && !req_take)
                      || ((aw_st == AW_DATA) && w_done && axi_wlast);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_st <= AW_IDLE;
      axi_awvalid <= 1'b0;
      axi_awaddr <= `NNA_ZERO32;
      axi_awlen <= `NNA_ZERO8;
      axi_wvalid <= 1'b0;
      axi_wlast <= 1'b0;
      axi_wdata <= `NNA_ZERO64;
      beats_left <= `NNA_LEN_ZERO;
      wr_req_ready <= 1'b0;
    end else begin
      wr_req_ready <= next_aw_idle;
      unique case (aw_st)
        AW_IDLE: begin
          if (req_take) begin
            aw_st <= AW_ADDR;
            axi_awaddr <= wr_req_addr;
            axi_awlen <= 8'(eff_len - `NNA_LEN_ONE);
            beats_left <= eff_len;
          end
        end
        AW_ADDR: begin
          axi_awvalid <= !aw_done && (axi_awvalid || aclk_rise); // only just after a bus edge
          if (aw_done) begin
            aw_st <= AW_DATA;
          end
        end
        AW_DATA: begin
          if (fifo_pop) begin
            axi_wvalid <= 1'b1;
            axi_wdata <= fifo_data;
            axi_wlast <= beats_left == `NNA_LEN_ONE;
            beats_left <= beats_left - `NNA_LEN_ONE;
          end else if (w_done) begin
            axi_wvalid <= 1'b0;
            if (axi_wlast) begin
              aw_st <= AW_IDLE;
              axi_wlast <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // fixed channel attributes
  always_ff @(posedge ref_clk) begin
    axi_awid <= `NNA_AWID;
    axi_wid <= `NNA_AWID;
    axi_wstrb <= `NNA_WSTRB;
    axi_awsize <= `NNA_AWSIZE;
    axi_awburst <= `NNA_AWBURST;
    axi_awlock <= `NNA_AWLOCK;
    axi_awcache <= `NNA_AWCACHE;
    axi_awprot <= `NNA_AWPROT;
    axi_awregion <= `NNA_AWREGION;
    axi_awqos <= `NNA_AWQOS;
    axi_bready <= `NNA_BREADY;
  end

  // write data buffer between engine and bus
  nna_fifo #(
    .W(`NNA_AXI_DW),
    .D(`NNA_FIFO_DEPTH)
  ) u_wfifo (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(wr_data_valid),
    .in_data(wr_data),
    .in_ready(wr_data_ready),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  reset_clear_a: assert property (disable iff (1'b0) rst |=> rd_rdy && !result_we && !axi_awvalid)
    else $error("outputs not cleared by reset");
  start_busy_a: assert property (go_run |=> !rd_rdy && eng_start && status[`NNA_ST_RUN] == 1'b0 ##1 status[`NNA_ST_RUN])
    else $error("start did not take the engine busy");
  run_ready_a: assert property (ctl == CT_RUN |-> !rd_rdy)
    else $error("ready high while running");
  finish_ready_a: assert property (go_idle |=> rd_rdy && ctl == CT_IDLE)
    else $error("finish did not raise ready");
  read_latency_a: assert property (rd_take |=> !port_ready [*6] ##1 (port_ready && port_rdata_valid))
    else $error("read latency is not seven cycles");
  read_data_a: assert property (port_rdata_valid |-> port_rdata == $past(mem_rdata))
    else $error("read data not taken at completion");
  port_decode_a: assert property (wr_take |=> mem_we && mem_bank == $past(port_ofs[16:13]))
    else $error("bank select mismatch");
  result_word_a: assert property (eng_res_valid |=> result_we && result_data == $past(eng_res_data))
    else $error("result strobe or word wrong");
  gpo_load_a: assert property (eng_gpo_we |=> gpo == $past(eng_gpo_data))
    else $error("general output not loaded");
  attr_fixed_a: assert property (##1 axi_awid == 8'h10 && axi_wstrb == 8'hFF && axi_awsize == 3'b011
    && axi_awburst == 2'b01 && axi_awcache == 4'h0 && axi_awprot == 3'b000 && axi_bready)
    else $error("fixed attribute wrong");
  burst_max_a: assert property (axi_awvalid |-> {1'b0, axi_awlen} < MAX_BURST)
    else $error("burst over the build limit");
  aw_hold_a: assert property (axi_awvalid && !aw_done |=> axi_awvalid && $stable(axi_awaddr))
    else $error("address dropped before handshake");
  w_hold_a: assert property (axi_wvalid && !w_done |=> axi_wvalid && $stable(axi_wdata))
    else $error("write beat dropped before handshake");
endmodule
